// ==== design/pb_seq_pkg.sv ====
// constants for the pushbutton power sequencer
// assumes a 40 MHz system clock
package pb_seq_pkg;
  localparam int CLK_HZ = 40000000;
  localparam real TICK_NS = 1820000.0;
  localparam int TICK_CYC = int'(TICK_NS * 40.0 / 1000.0);
  localparam real TICK_MS = 1.82;
  localparam int SUPPLY_SETTLE_TICKS = int'($ceil(100.0 / TICK_MS));
  localparam int POWERUP_TICKS = int'($ceil(5000.0 / TICK_MS));
  localparam int PDN_WAIT_TICKS = int'($ceil(1000.0 / TICK_MS));
  localparam int GOOD_DELAY_TICKS = int'($ceil(1.8 / TICK_MS));
  localparam int DEBOUNCE_TICKS = int'($ceil(50.0 / TICK_MS));
  localparam int WAKE_PRESS_TICKS = int'($ceil(400.0 / TICK_MS));
  localparam int KILL_PRESS_TICKS = int'($ceil(14000.0 / TICK_MS));
  localparam int TCNT_W = 16;
  localparam int PCNT_W = 24;
  localparam int SCNT_W = 14;
  localparam int PRESC_W = 17;
  localparam logic RESET_STATUS_HIGH = 1'b1;
endpackage

// ==== design/pb_seq.sv ====
// pushbutton power sequencer: regulator enables, debounced button, power good
// assumes inputs synchronous to clk_in; in_reg inputs come from the regulators
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - soft-off plus supply: settle then second power-up
// - keep-on low after window disables step-down
// - power good low until step-down regulates
// - no battery: reset power-down, shutdown, supply wakes
// - shutdown with keep-on goes straight on
// - keep-on power-up: good after both regulate
// - debounced button low after 50ms press
// - keep-on low: normal power-down then soft-off
// - power-down wait is cut short only by low output or long-press kill
// - power good held across keep-on power-down
// - held button must release before waking
// - undervoltage forces normal power-down, step-down off
// - undervoltage drops linear and power good
// - cleared undervoltage: soft-off then power-up
// - soft-off with keep-on goes on after undervoltage
// - very low output acts as power-on reset
// - 14s press kills to reset power-down
// - reset power-down then shutdown, linear off
// - after kill, release then 400ms press
// - all timing from 1.82ms tick
// - kill press starts powered; status released when off
module pb_seq
  import pb_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic button_n_in,
  input wire logic keep_on_in,
  input wire logic external_supply_in,
  input wire logic battery_present_in,
  input wire logic out_uvlo_in,
  input wire logic out_por_in,
  input wire logic stepdown_in_reg_in,
  input wire logic linear_in_reg_in,
  output logic stepdown_en_out,
  output logic linear_en_out,
  output logic button_status_out,
  output logic supplies_good_out
);
  typedef enum logic [2:0] {
    reset_powerdown_state,
    deep_shutdown_state,
    first_powerup_state,
    second_powerup_state,
    powered_on_state,
    normal_powerdown_state,
    soft_off_state
  } seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [PRESC_W-1:0] presc;
    logic tick;
    logic [TCNT_W-1:0] tcnt;
    logic [SCNT_W-1:0] scnt;
    logic [PCNT_W-1:0] pcnt;
    logic kill_armed;
    logic kill_done;
    logic need_release;
    logic [7:0] gcnt;
    logic [7:0] hold;
    logic bstat;
    logic sd_en;
    logic ln_en;
    logic good;
  } seq_regs_t;

  seq_regs_t cur_ff;
  seq_regs_t nxt_cur;

  logic pressed;
  logic powered;
  logic regs_ok;

  always_comb begin
    nxt_cur = cur_ff;
    pressed = ~button_n_in;
    powered = (cur_ff.st == first_powerup_state) || (cur_ff.st == second_powerup_state)
              || (cur_ff.st == powered_on_state);
    regs_ok = (!cur_ff.sd_en || stepdown_in_reg_in) && (!cur_ff.ln_en || linear_in_reg_in)
              && (cur_ff.sd_en || cur_ff.ln_en);
    // state machine tick prescaler
    nxt_cur.tick = 1'b0;
    if (cur_ff.presc == PRESC_W'(TICK_CYCLES - 1)) begin
      nxt_cur.presc = '0;
      nxt_cur.tick = 1'b1;
    end else begin
      nxt_cur.presc = cur_ff.presc + 1'b1;
    end
    if (cur_ff.tick && cur_ff.tcnt != '1) begin
      nxt_cur.tcnt = cur_ff.tcnt + 1'b1;
    end
    // press length counter, restarted by release
    if (!pressed) begin
      nxt_cur.pcnt = '0;
      nxt_cur.need_release = 1'b0;
      nxt_cur.kill_armed = 1'b0;
      nxt_cur.kill_done = 1'b0;
    end else if (cur_ff.tick && cur_ff.pcnt != '1) begin
      nxt_cur.pcnt = cur_ff.pcnt + 1'b1;
    end
    if (pressed && cur_ff.pcnt == '0 && powered) begin
      nxt_cur.kill_armed = 1'b1;
    end
    // debounced status, minimum low width
    if (cur_ff.tick && cur_ff.hold != '0) begin
      nxt_cur.hold = cur_ff.hold - 1'b1;
    end
    if (!powered) begin
      nxt_cur.bstat = 1'b1;
      nxt_cur.hold = '0;
    end else if (pressed && !cur_ff.need_release && cur_ff.pcnt >= PCNT_W'(DEBOUNCE_TICKS)
                 && cur_ff.bstat) begin
      nxt_cur.bstat = 1'b0;
      nxt_cur.hold = 8'(DEBOUNCE_TICKS);
    end else if (!pressed && cur_ff.hold == '0) begin
      nxt_cur.bstat = 1'b1;
    end
    // supply settle counter, restarts when supply drops
    if (!external_supply_in) begin
      nxt_cur.scnt = '0;
    end else if (cur_ff.tick && cur_ff.scnt != '1) begin
      nxt_cur.scnt = cur_ff.scnt + 1'b1;
    end
    case (cur_ff.st)
      reset_powerdown_state: begin
        nxt_cur.sd_en = 1'b0;
        if (cur_ff.tcnt >= TCNT_W'(PDN_WAIT_TICKS)) begin
          nxt_cur.st = deep_shutdown_state;
          nxt_cur.ln_en = 1'b0;
          nxt_cur.tcnt = '0;
        end
      end
      deep_shutdown_state: begin
        nxt_cur.sd_en = 1'b0;
        nxt_cur.ln_en = 1'b0;
        if (keep_on_in && !out_uvlo_in) begin
          nxt_cur.st = powered_on_state;
          nxt_cur.sd_en = 1'b1;
          nxt_cur.ln_en = 1'b1;
          nxt_cur.good = 1'b0;
          nxt_cur.tcnt = '0;
        end else if (external_supply_in && !battery_present_in) begin
          nxt_cur.st = first_powerup_state;
          nxt_cur.ln_en = 1'b1;
          nxt_cur.tcnt = '0;
        end else if ((external_supply_in && cur_ff.scnt >= SCNT_W'(SUPPLY_SETTLE_TICKS))
                     || (pressed && !cur_ff.need_release
                         && cur_ff.pcnt >= PCNT_W'(WAKE_PRESS_TICKS))) begin
          nxt_cur.st = first_powerup_state;
          nxt_cur.ln_en = 1'b1;
          nxt_cur.tcnt = '0;
          nxt_cur.need_release = 1'b1;
        end
      end
      first_powerup_state, second_powerup_state: begin
        nxt_cur.ln_en = 1'b1;
        if (cur_ff.ln_en && linear_in_reg_in) begin
          nxt_cur.sd_en = 1'b1;
        end
        if (cur_ff.tcnt >= TCNT_W'(POWERUP_TICKS)) begin
          nxt_cur.st = powered_on_state;
          nxt_cur.sd_en = keep_on_in;
          nxt_cur.tcnt = '0;
        end
      end
      powered_on_state: begin
        nxt_cur.ln_en = 1'b1;
        nxt_cur.sd_en = keep_on_in;
        if (!keep_on_in || out_uvlo_in) begin
          nxt_cur.st = normal_powerdown_state;
          nxt_cur.sd_en = 1'b0;
          nxt_cur.tcnt = '0;
          nxt_cur.need_release = pressed;
        end
      end
      normal_powerdown_state: begin
        nxt_cur.sd_en = 1'b0;
        nxt_cur.ln_en = 1'b1;
        if (pressed) begin
          nxt_cur.need_release = 1'b1;
        end
        if (cur_ff.tcnt >= TCNT_W'(PDN_WAIT_TICKS)) begin
          nxt_cur.st = soft_off_state;
          nxt_cur.tcnt = '0;
        end
      end
      soft_off_state: begin
        nxt_cur.ln_en = 1'b1;
        nxt_cur.sd_en = 1'b0;
        if (keep_on_in && !out_uvlo_in) begin
          nxt_cur.st = powered_on_state;
          nxt_cur.sd_en = 1'b1;
          nxt_cur.tcnt = '0;
        end else if ((external_supply_in && !out_uvlo_in
                      && cur_ff.scnt >= SCNT_W'(SUPPLY_SETTLE_TICKS))
                     || (pressed && !cur_ff.need_release
                         && cur_ff.pcnt >= PCNT_W'(WAKE_PRESS_TICKS))) begin
          nxt_cur.st = second_powerup_state;
          nxt_cur.sd_en = 1'b1;
          nxt_cur.tcnt = '0;
          nxt_cur.need_release = pressed;
        end
      end
      default: nxt_cur.st = reset_powerdown_state;
    endcase
    // long-press kill, press must have started powered
    if (cur_ff.kill_armed && !cur_ff.kill_done && cur_ff.pcnt >= PCNT_W'(KILL_PRESS_TICKS)
        && cur_ff.st != deep_shutdown_state && cur_ff.st != reset_powerdown_state) begin
      nxt_cur.st = reset_powerdown_state;
      nxt_cur.sd_en = 1'b0;
      nxt_cur.tcnt = '0;
      nxt_cur.kill_done = 1'b1;
      nxt_cur.need_release = 1'b1;
    end
    // output low voltage acts as power-on reset
    if (out_por_in && cur_ff.st != reset_powerdown_state
        && cur_ff.st != deep_shutdown_state) begin
      nxt_cur.st = reset_powerdown_state;
      nxt_cur.sd_en = 1'b0;
      nxt_cur.tcnt = '0;
    end
    // undervoltage drops the linear regulator
    if (out_uvlo_in) begin
      nxt_cur.ln_en = 1'b0;
      nxt_cur.sd_en = 1'b0;
    end
    // power good qualification
    if (nxt_cur.sd_en && !cur_ff.sd_en) begin
      nxt_cur.good = 1'b0;
      nxt_cur.gcnt = '0;
    end else if (!regs_ok || out_uvlo_in) begin
      nxt_cur.gcnt = '0;
      if (cur_ff.ln_en && !linear_in_reg_in || out_uvlo_in || !nxt_cur.ln_en) begin
        nxt_cur.good = 1'b0;
      end
    end else if (cur_ff.tick) begin
      if (cur_ff.gcnt >= 8'(GOOD_DELAY_TICKS)) begin
        nxt_cur.good = 1'b1;
      end else begin
        nxt_cur.gcnt = cur_ff.gcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cur_ff <= '{st: reset_powerdown_state, presc: '0, tick: 1'b0, tcnt: '0, scnt: '0,
                  pcnt: '0, kill_armed: 1'b0, kill_done: 1'b0, need_release: 1'b1,
                  gcnt: '0, hold: '0, bstat: RESET_STATUS_HIGH,
                  sd_en: 1'b0, ln_en: 1'b1, good: 1'b0};
    end else if (clk_en_in) begin
      cur_ff <= nxt_cur;
    end
  end

  assign stepdown_en_out = cur_ff.sd_en;
  assign linear_en_out = cur_ff.ln_en;
  assign button_status_out = cur_ff.bstat;
  assign supplies_good_out = cur_ff.good;

  a_status_when_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cur_ff.st == deep_shutdown_state || cur_ff.st == soft_off_state) |=> button_status_out)
    else $error("button status low while off");
  a_pdn_stepdown_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cur_ff.st == normal_powerdown_state |-> !stepdown_en_out)
    else $error("step-down enabled in power-down");
  a_shutdown_all_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cur_ff.st == deep_shutdown_state && $past(cur_ff.st) == deep_shutdown_state)
    |-> !linear_en_out && !stepdown_en_out)
    else $error("regulator on in deep shutdown");
  a_keep_on_wake: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == deep_shutdown_state && keep_on_in && !out_uvlo_in)
    |=> cur_ff.st == powered_on_state && stepdown_en_out && linear_en_out)
    else $error("keep-on did not power up");
  a_keep_on_drop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == powered_on_state && !keep_on_in)
    |=> cur_ff.st == normal_powerdown_state)
    else $error("keep-on low did not power down");
  a_uvlo_linear_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && out_uvlo_in) |=> !linear_en_out && !supplies_good_out)
    else $error("undervoltage left linear on");
  a_por_reset_pdn: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && out_por_in && cur_ff.st == powered_on_state)
    |=> cur_ff.st == reset_powerdown_state)
    else $error("output por not handled");
  a_sd_enable_good: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(stepdown_en_out) |-> !supplies_good_out)
    else $error("power good high at step-down enable");
  a_pdn_keeps_linear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == normal_powerdown_state && !out_uvlo_in) |=> linear_en_out)
    else $error("linear off in power-down");
  a_good_kept_pdn: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == powered_on_state && !keep_on_in && !out_uvlo_in
     && linear_in_reg_in && supplies_good_out) |=> supplies_good_out)
    else $error("power good dropped at keep-on power-down");
  a_pdn_wait_held: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == normal_powerdown_state && !out_por_in && !cur_ff.kill_armed
     && cur_ff.tcnt < TCNT_W'(PDN_WAIT_TICKS)) |=> cur_ff.st == normal_powerdown_state)
    else $error("power-down wait cut short");
  a_pdn_to_soft_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == normal_powerdown_state && !out_por_in && !cur_ff.kill_armed
     && cur_ff.tcnt >= TCNT_W'(PDN_WAIT_TICKS)) |=> cur_ff.st == soft_off_state)
    else $error("power-down wait did not end in soft-off");
  a_pdn_ignores_inputs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == normal_powerdown_state)
    |=> !(cur_ff.st inside {first_powerup_state, second_powerup_state, powered_on_state}))
    else $error("power-down wait left for a powered state");
  a_kill_to_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == powered_on_state && cur_ff.kill_armed && !cur_ff.kill_done
     && cur_ff.pcnt >= PCNT_W'(KILL_PRESS_TICKS))
    |=> cur_ff.st == reset_powerdown_state && !stepdown_en_out)
    else $error("long press did not kill");
  a_reset_pdn_exit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == reset_powerdown_state
     && cur_ff.tcnt >= TCNT_W'(PDN_WAIT_TICKS)) |=> cur_ff.st == deep_shutdown_state
    && !linear_en_out)
    else $error("reset power-down did not shut down");
  a_status_debounced: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(button_status_out) |-> $past(cur_ff.pcnt) >= PCNT_W'(DEBOUNCE_TICKS))
    else $error("button status fell before debounce");
  a_uvlo_to_pdn: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == powered_on_state && out_uvlo_in && !out_por_in
     && !cur_ff.kill_armed) |=> cur_ff.st == normal_powerdown_state && !stepdown_en_out)
    else $error("undervoltage did not force power-down");
  a_soft_off_keep_on: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == soft_off_state && keep_on_in && !out_uvlo_in && !out_por_in
     && !cur_ff.kill_armed) |=> cur_ff.st == powered_on_state && stepdown_en_out)
    else $error("keep-on did not restart from soft-off");
  a_supply_wake: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == soft_off_state && !keep_on_in && external_supply_in
     && !out_uvlo_in && !out_por_in && !cur_ff.kill_armed
     && cur_ff.scnt >= SCNT_W'(SUPPLY_SETTLE_TICKS))
    |=> cur_ff.st == second_powerup_state && stepdown_en_out)
    else $error("settled supply did not power up");
  a_no_battery_wake: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clk_en_in && cur_ff.st == deep_shutdown_state && !keep_on_in && external_supply_in
     && !battery_present_in && !out_uvlo_in) |=> cur_ff.st == first_powerup_state
    && linear_en_out)
    else $error("supply without battery did not power up");
endmodule

`default_nettype wire

// ==== testbench/reg_far_model.sv ====
// regulator model: in-regulation flags follow the enables
// assumes enables come from registers clocked by clk_in
`timescale 1ns/100ps
`default_nettype none
module reg_far_model #(
  parameter int SETTLE_CYC = 8
) (
  input wire logic clk_in,
  input wire logic stepdown_en_in,
  input wire logic linear_en_in,
  output logic stepdown_in_reg_out,
  output logic linear_in_reg_out
);
  int sd_cnt = 0;
  int ln_cnt = 0;
  always @(posedge clk_in) begin
    sd_cnt <= stepdown_en_in ? sd_cnt + 1 : 0;
    ln_cnt <= linear_en_in ? ln_cnt + 1 : 0;
  end
  // a disabled regulator drops out of regulation at once
  assign stepdown_in_reg_out = stepdown_en_in && (sd_cnt >= SETTLE_CYC);
  assign linear_in_reg_out = linear_en_in && (ln_cnt >= SETTLE_CYC);
endmodule
`default_nettype wire

// ==== testbench/tb_pb_seq.sv ====
// self-checking bench for the pushbutton power sequencer
// assumes the regulator model; tick shortened to 4 clocks
`timescale 1ns/100ps
`default_nettype none
module tb_pb_seq;
  import pb_seq_pkg::*;
  localparam int T = 4;
  localparam int SD = 3;
  localparam int LN = 2;
  localparam int ST = 1;
  localparam int PG = 0;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic btn_n = 1'b1;
  logic keep = 1'b0;
  logic supply = 1'b0;
  logic bat = 1'b1;
  logic uvlo = 1'b0;
  logic por = 1'b0;
  logic clk_en = 1'b1;
  logic sd_reg, ln_reg, sd_en, ln_en, status, good;
  wire logic [3:0] outs = {sd_en, ln_en, status, good};
  int error_cnt = 0;
  int checks_done = 0;
  always #12.5 clk_in = ~clk_in;
  pb_seq #(.TICK_CYCLES(T)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .clk_en_in(clk_en), .button_n_in(btn_n), .keep_on_in(keep),
    .external_supply_in(supply), .battery_present_in(bat), .out_uvlo_in(uvlo),
    .out_por_in(por), .stepdown_in_reg_in(sd_reg), .linear_in_reg_in(ln_reg),
    .stepdown_en_out(sd_en), .linear_en_out(ln_en),
    .button_status_out(status), .supplies_good_out(good));
  reg_far_model #(.SETTLE_CYC(2 * T)) i_regs (.clk_in(clk_in), .stepdown_en_in(sd_en),
    .linear_en_in(ln_en), .stepdown_in_reg_out(sd_reg), .linear_in_reg_out(ln_reg));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic chk(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fail(msg);
    end
  endtask
  // wait for an output level; lo and hi bound the delay in ticks
  task automatic wait_lvl(input int idx, input logic val, input int lo, input int hi);
    int n;
    n = 0;
    while (outs[idx] !== val) begin
      @(negedge clk_in);
      n++;
      if (n > hi * T + 4) begin
        fail("output level not reached");
        test_done();
      end
    end
    checks_done++;
    if (n < lo * T) begin
      fail("output changed too early");
    end
  endtask
  task automatic hold(input logic [3:0] exp, input int cyc);
    repeat (cyc) begin
      @(negedge clk_in);
      checks_done++;
      if (outs !== exp) begin
        fail("outputs moved while held");
      end
    end
  endtask
  task automatic t_reset();
    chk(sd_en, 1'b0, "step-down on in reset");
    chk(ln_en, 1'b1, "linear off in reset");
    chk(status, 1'b1, "status low in reset");
    wait_lvl(LN, 1'b0, PDN_WAIT_TICKS - 1, PDN_WAIT_TICKS + 2);
    $display("reset test done");
  endtask
  task automatic t_keep_wake();
    @(negedge clk_in);
    keep = 1'b1;
    clk_en = 1'b0;
    hold(4'b0010, 2 * T);
    clk_en = 1'b1;
    wait_lvl(SD, 1'b1, 0, 1);
    chk(ln_en, 1'b1, "linear not with step-down");
    chk(good, 1'b0, "power good early");
    wait_lvl(PG, 1'b1, GOOD_DELAY_TICKS, GOOD_DELAY_TICKS + 5);
    btn_n = 1'b0;
    wait_lvl(ST, 1'b0, DEBOUNCE_TICKS - 1, DEBOUNCE_TICKS + 2);
    btn_n = 1'b1;
    wait_lvl(ST, 1'b1, DEBOUNCE_TICKS - 1, DEBOUNCE_TICKS + 2);
    $display("keep-on wake test done");
  endtask
  task automatic t_keep_off();
    keep = 1'b0;
    wait_lvl(SD, 1'b0, 0, 1);
    chk(good, 1'b1, "power good dropped");
    btn_n = 1'b0;
    keep = 1'b1;
    hold(4'b0111, 3 * T);
    keep = 1'b0;
    hold(4'b0111, (PDN_WAIT_TICKS + 20) * T);
    btn_n = 1'b1;
    $display("keep-on off test done");
  endtask
  task automatic t_supply();
    supply = 1'b1;
    wait_lvl(SD, 1'b1, SUPPLY_SETTLE_TICKS - 1, SUPPLY_SETTLE_TICKS + 2);
    wait_lvl(PG, 1'b0, 0, 1);
    wait_lvl(PG, 1'b1, GOOD_DELAY_TICKS, GOOD_DELAY_TICKS + 5);
    supply = 1'b0;
    wait_lvl(SD, 1'b0, POWERUP_TICKS - GOOD_DELAY_TICKS - 8, POWERUP_TICKS + 2);
    repeat ((PDN_WAIT_TICKS + 4) * T) @(negedge clk_in);
    $display("supply test done");
  endtask
  task automatic t_uvlo();
    keep = 1'b1;
    wait_lvl(SD, 1'b1, 0, 1);
    wait_lvl(PG, 1'b1, 0, GOOD_DELAY_TICKS + 5);
    uvlo = 1'b1;
    wait_lvl(SD, 1'b0, 0, 1);
    wait_lvl(LN, 1'b0, 0, 1);
    wait_lvl(PG, 1'b0, 0, 1);
    uvlo = 1'b0;
    wait_lvl(PG, 1'b1, GOOD_DELAY_TICKS, GOOD_DELAY_TICKS + 5);
    wait_lvl(SD, 1'b1, PDN_WAIT_TICKS - GOOD_DELAY_TICKS - 8, PDN_WAIT_TICKS + 2);
    $display("undervoltage test done");
  endtask
  task automatic t_por();
    por = 1'b1;
    wait_lvl(SD, 1'b0, 0, 1);
    por = 1'b0;
    keep = 1'b0;
    chk(ln_en, 1'b1, "linear off after low output");
    wait_lvl(LN, 1'b0, PDN_WAIT_TICKS - 1, PDN_WAIT_TICKS + 2);
    $display("low output test done");
  endtask
  task automatic t_kill();
    keep = 1'b1;
    wait_lvl(SD, 1'b1, 0, 1);
    btn_n = 1'b0;
    wait_lvl(SD, 1'b0, KILL_PRESS_TICKS - 1, KILL_PRESS_TICKS + 2);
    keep = 1'b0;
    chk(ln_en, 1'b1, "linear off at kill");
    wait_lvl(LN, 1'b0, PDN_WAIT_TICKS - 1, PDN_WAIT_TICKS + 2);
    wait_lvl(PG, 1'b0, 0, 1);
    hold(4'b0010, (WAKE_PRESS_TICKS + 8) * T);
    btn_n = 1'b1;
    hold(4'b0010, T);
    btn_n = 1'b0;
    wait_lvl(LN, 1'b1, WAKE_PRESS_TICKS - 1, WAKE_PRESS_TICKS + 2);
    btn_n = 1'b1;
    $display("kill test done");
  endtask
  task automatic t_no_battery();
    reset_n_in = 1'b0;
    bat = 1'b0;
    supply = 1'b1;
    repeat (3) @(negedge clk_in);
    reset_n_in = 1'b1;
    wait_lvl(SD, 1'b1, PDN_WAIT_TICKS - 1, PDN_WAIT_TICKS + 3);
    $display("no battery test done");
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    reset_n_in = 1'b1;
    t_reset();
    t_keep_wake();
    t_keep_off();
    t_supply();
    t_uvlo();
    t_por();
    t_kill();
    t_no_battery();
    test_done();
  end
endmodule
`default_nettype wire
